// File: src/reset_cause_consts.vh
/*
 * Constants of the reset-cause capture block: register address,
 * bit positions of the cause register, interrupt side registers,
 * enable mask, reset values and the forced-reset pulse length.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef RESET_CAUSE_CONSTS_VH
`define RESET_CAUSE_CONSTS_VH

`define ADDR_CAUSE       8'hEF
`define ADDR_IRQ_STATUS  8'hF0
`define ADDR_IRQ_MASK    8'hF1

`define BIT_RTC          7
`define BIT_FLASH        6
`define BIT_CMP          5
`define BIT_SOFT         4
`define BIT_WDOG         3
`define BIT_MCLK         2
`define BIT_POWER        1
`define BIT_PIN          0

`define ENABLE_MASK      8'hA6
`define CAUSE_RESET      8'h02
`define ENABLE_RESET     8'h00
`define ZERO_BYTE        8'h00

// forced reset held for at least this many ns
`define FORCE_NS         32
`define CLK_NS           4
`define FORCE_CYCLES     ((`FORCE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// File: src/pin_sync3.v
/*
 * Three-stage synchroniser for one asynchronous reset-source input.
 * A change counts once the second and third stages agree.
 * Assumes clk is the system clock and rst is asynchronous active high.
 */
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 (
    input  wire clk,
    input  wire rst,
    input  wire din,
    output reg  dout
);

reg s1;
reg s2;
reg s3;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        s1   <= 1'b0;
        s2   <= 1'b0;
        s3   <= 1'b0;
        dout <= 1'b0;
    end else begin
        s1 <= din;
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
            dout <= s3;
        end
    end
end

endmodule // pin_sync3

`default_nettype wire

// File: src/reset_cause_capture.v
/*
 * Reset-cause capture: records which source caused the latest system
 * reset, holds the optional-source enables, lets software force a
 * reset, and raises a maskable interrupt on caught source events.
 * Assumes: rst is the power-on reset (async, high); source requests
 * are asynchronous levels; the register port is the core's byte-wide
 * special-function-register port with read data one cycle later;
 * system_reset_req drives the chip-wide reset outside this block,
 * which in turn does not reset this block (only power-on does).
 */
`timescale 1ns/100ps
`default_nettype none
`include "reset_cause_consts.vh"

module reset_cause_capture (
    input  wire       clk,
    input  wire       rst,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       supply_fail,
    input  wire       pin_reset_n,
    input  wire       missing_clock_detector,
    input  wire       watchdog_overflow,
    input  wire       comparator_trip,
    input  wire       flash_fault,
    input  wire       rtc_event,
    output wire       system_reset_req,
    output wire       irq
);

// =====================================================================
// source synchronisers
// =====================================================================
wire [7:0] raw_src;
wire [7:0] src;

assign raw_src[`BIT_RTC]   = rtc_event;
assign raw_src[`BIT_FLASH] = flash_fault;
assign raw_src[`BIT_CMP]   = comparator_trip;
assign raw_src[`BIT_SOFT]  = 1'b0;
assign raw_src[`BIT_WDOG]  = watchdog_overflow;
assign raw_src[`BIT_MCLK]  = missing_clock_detector;
assign raw_src[`BIT_POWER] = supply_fail;
assign raw_src[`BIT_PIN]   = ~pin_reset_n;

genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
        if (gi == `BIT_SOFT) begin : g_none
            assign src[gi] = 1'b0;
        end else begin : g_pin
            pin_sync3 u_sync (
                .clk  (clk),
                .rst  (rst),
                .din  (raw_src[gi]),
                .dout (src[gi])
            );
        end
    end
endgenerate

// =====================================================================
// register decode
// =====================================================================
function hit;
    input [7:0] addr;
    input [7:0] want;
    begin
        hit = (addr == want);
    end
endfunction

wire wr_cause  = reg_wr & hit(reg_addr, `ADDR_CAUSE);
wire wr_status = reg_wr & hit(reg_addr, `ADDR_IRQ_STATUS);
wire wr_mask   = reg_wr & hit(reg_addr, `ADDR_IRQ_MASK);

// =====================================================================
// enables and reset request
// =====================================================================
reg  [7:0] enable;
reg  [7:0] cause;
reg  [7:0] irq_status;
reg  [7:0] irq_mask;
reg  [3:0] force_cnt;
reg        in_reset;
reg  [7:0] next_enable;
reg  [7:0] next_cause;

// soft force only when bit 4 is written with a one
wire soft_force = wr_cause & reg_wdata[`BIT_SOFT];

// gated requests: fixed sources always, optional ones per enable
wire [7:0] armed;
assign armed[`BIT_RTC]   = src[`BIT_RTC]   & enable[`BIT_RTC];
assign armed[`BIT_FLASH] = src[`BIT_FLASH];
assign armed[`BIT_CMP]   = src[`BIT_CMP]   & enable[`BIT_CMP];
assign armed[`BIT_SOFT]  = soft_force;
assign armed[`BIT_WDOG]  = src[`BIT_WDOG];
assign armed[`BIT_MCLK]  = src[`BIT_MCLK]  & enable[`BIT_MCLK];
assign armed[`BIT_POWER] = src[`BIT_POWER] & enable[`BIT_POWER];
assign armed[`BIT_PIN]   = src[`BIT_PIN];

wire any_armed = |armed;

// pick a single cause; highest bit wins on a tie
function [7:0] one_hot_top;
    input [7:0] v;
    integer k;
    begin
        one_hot_top = `ZERO_BYTE;
        for (k = 0; k < 8; k = k + 1) begin
            if (v[k]) begin
                one_hot_top = 8'h01 << k;
            end
        end
    end
endfunction

// enable bits are written only on their own writable lanes
always @* begin
    next_enable = enable;
    if (wr_cause) begin
        next_enable = reg_wdata & `ENABLE_MASK;
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        enable <= `ENABLE_RESET;
    end else begin
        enable <= next_enable;
    end
end

// =====================================================================
// cause capture
// =====================================================================
// power-on leaves the power flag alone set; a new reset replaces all
// flags held while the pulse runs, so one reset records one cause
always @* begin
    next_cause = cause;
    if (any_armed && !in_reset) begin
        next_cause = one_hot_top(armed);
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        cause <= `CAUSE_RESET;
    end else begin
        cause <= next_cause;
    end
end

// =====================================================================
// reset pulse sequencer
// =====================================================================
localparam [1:0] ST_RUN   = 2'b00;  // no reset requested
localparam [1:0] ST_HOLD  = 2'b01;  // an armed request still stands
localparam [1:0] ST_DRAIN = 2'b10;  // request gone, counting out the pulse

// pulse length cut to the counter width on purpose
localparam [31:0] FORCE_FULL = `FORCE_CYCLES;

wire [3:0] force_load = FORCE_FULL[3:0];
reg  [1:0] state;
reg  [1:0] next_state;
reg  [3:0] next_force_cnt;

always @* begin
    next_state     = state;
    next_force_cnt = force_cnt;
    case (state)
        ST_RUN: begin
            // first armed request starts the pulse
            if (any_armed) begin
                next_state     = ST_HOLD;
                next_force_cnt = force_load;
            end
        end
        ST_HOLD: begin
            // a standing request keeps reloading the length
            if (any_armed) begin
                next_force_cnt = force_load;
            end else begin
                next_state     = ST_DRAIN;
                next_force_cnt = force_cnt - 4'h1;
            end
        end
        ST_DRAIN: begin
            // a new request restarts the full length
            if (any_armed) begin
                next_state     = ST_HOLD;
                next_force_cnt = force_load;
            end else if (force_cnt != 4'h0) begin
                next_force_cnt = force_cnt - 4'h1;
            end else begin
                next_state = ST_RUN;
            end
        end
        default: begin
            next_state     = ST_RUN;
            next_force_cnt = 4'h0;
        end
    endcase
end

// request is a flop so the chip reset never sees a decode glitch
always @(posedge clk or posedge rst) begin
    if (rst) begin
        state     <= ST_RUN;
        force_cnt <= 4'h0;
        in_reset  <= 1'b0;
    end else begin
        state     <= next_state;
        force_cnt <= next_force_cnt;
        in_reset  <= (next_state != ST_RUN);
    end
end

assign system_reset_req = in_reset;

// =====================================================================
// interrupt status and mask
// =====================================================================
reg  [7:0] next_irq_status;
reg  [7:0] armed_q;

// a status bit latches the rising edge of its armed request, so a
// source that stays high can still be cleared by software
wire [7:0] armed_rise = armed & ~armed_q;

always @* begin
    next_irq_status = irq_status;
    if (wr_status) begin
        next_irq_status = next_irq_status & ~reg_wdata;
    end
    // set wins over a clear in the same cycle
    next_irq_status = next_irq_status | armed_rise;
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        irq_status <= `ZERO_BYTE;
        irq_mask   <= `ZERO_BYTE;
        armed_q    <= `ZERO_BYTE;
    end else begin
        irq_status <= next_irq_status;
        armed_q    <= armed;
        if (wr_mask) begin
            irq_mask <= reg_wdata;
        end
    end
end

assign irq = |(irq_status & irq_mask);

// =====================================================================
// read port
// =====================================================================
reg  [7:0] next_rdata;

// reads carry no side effect, but read-modify-write of the cause byte is not safe
// limitation: a read-back bit 4 written unchanged forces a new reset,
// so software clears it before writing the byte back
always @* begin
    next_rdata = `ZERO_BYTE;
    if (reg_rd) begin
        case (reg_addr)
            `ADDR_CAUSE: begin
                next_rdata = cause;
            end
            `ADDR_IRQ_STATUS: begin
                next_rdata = irq_status;
            end
            `ADDR_IRQ_MASK: begin
                next_rdata = irq_mask;
            end
            default: begin
                next_rdata = `ZERO_BYTE;
            end
        endcase
    end
end

// read data stand only in the cycle after the strobe
always @(posedge clk or posedge rst) begin
    if (rst) begin
        reg_rdata <= `ZERO_BYTE;
    end else begin
        reg_rdata <= next_rdata;
    end
end

endmodule // reset_cause_capture

`default_nettype wire

// File: bench/reset_cause_properties.sv
/* checker for reset_cause_capture port behaviour.
   assumes bind into each reset_cause_capture instance. */
`timescale 1ns/100ps
`default_nettype none
`include "reset_cause_consts.vh"
module reset_cause_props (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       pin_reset_n,
    input wire logic       missing_clock_detector,
    input wire logic       watchdog_overflow,
    input wire logic       comparator_trip,
    input wire logic       flash_fault,
    input wire logic       rtc_event,
    input wire logic       system_reset_req
);
    // ================================
    // enables as last written
    logic [7:0] en;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            en <= 8'h00;
        else if (reg_wr && reg_addr == `ADDR_CAUSE)
            en <= reg_wdata & `ENABLE_MASK;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_soft;
        reg_wr && reg_addr == `ADDR_CAUSE && reg_wdata[4] && !system_reset_req;
    endsequence
    sequence s_up;
        ##[1:10] system_reset_req;
    endsequence
    property p_soft; s_soft |=> system_reset_req; endproperty
    property p_hold; $rose(system_reset_req) |-> system_reset_req[*8];
    endproperty
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    property p_wdog; $rose(watchdog_overflow) && !system_reset_req |-> s_up;
    endproperty
    property p_flash; $rose(flash_fault) && !system_reset_req |-> s_up;
    endproperty
    property p_pin; $fell(pin_reset_n) && !system_reset_req |-> s_up;
    endproperty
    property p_cmp;
        $rose(comparator_trip) && en[5] && !system_reset_req |-> s_up;
    endproperty
    property p_mcd;
        $rose(missing_clock_detector) && en[2] && !system_reset_req |-> s_up;
    endproperty
    property p_rtc; $rose(rtc_event) && en[7] && !system_reset_req |-> s_up;
    endproperty
    a_soft: assert property (p_soft) else $error("no forced reset");
    a_hold: assert property (p_hold) else $error("reset too short");
    a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
    a_wdog: assert property (p_wdog) else $error("no watchdog reset");
    a_flash: assert property (p_flash) else $error("no flash reset");
    a_pin: assert property (p_pin) else $error("no pin reset");
    a_cmp: assert property (p_cmp) else $error("no comparator reset");
    a_mcd: assert property (p_mcd) else $error("no clock-loss reset");
    a_rtc: assert property (p_rtc) else $error("no rtc reset");
endmodule // reset_cause_props
bind reset_cause_capture reset_cause_props chk_u (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_reset_n(pin_reset_n),
    .missing_clock_detector(missing_clock_detector),
    .watchdog_overflow(watchdog_overflow),
    .comparator_trip(comparator_trip), .flash_fault(flash_fault),
    .rtc_event(rtc_event), .system_reset_req(system_reset_req));
`default_nettype wire

// File: bench/tb.sv
/* tb: register-level tests of reset_cause_capture.
   assumes design and checker files are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "reset_cause_consts.vh"
module tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] src = 8'h00;
    wire  [7:0] reg_rdata;
    wire        system_reset_req;
    wire        irq;
    int         err_total = 0;
    int         n_tests = 0;
    always #2 clk = ~clk;
    reset_cause_capture dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .supply_fail(src[1]), .pin_reset_n(~src[0]),
        .missing_clock_detector(src[2]), .watchdog_overflow(src[3]),
        .comparator_trip(src[5]), .flash_fault(src[6]), .rtc_event(src[7]),
        .system_reset_req(system_reset_req), .irq(irq));
    // ================================
    // bus, check, source-pulse and close-out tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic wait_req(input logic v);
        int n = 0;
        while (system_reset_req !== v && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h00, system_reset_req}, {7'h00, v});
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        src[i] <= 1'b1;
        wait_req(1'b1);
        @(posedge clk);
        src[i] <= 1'b0;
        wait_req(1'b0);
        rd(`ADDR_CAUSE, 8'h01 << i);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        close_out();
    end
    // ================================
    // tests
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(`ADDR_CAUSE, `CAUSE_RESET);
        rd(8'h55, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr(`ADDR_CAUSE, 8'h10);
        wait_req(1'b1);
        wait_req(1'b0);
        rd(`ADDR_CAUSE, 8'h10);
        wr(`ADDR_CAUSE, 8'hEF);
        rd(`ADDR_CAUSE, 8'h10);
        for (int i = 7; i >= 0; i--)
            if (i != 4)
                pulse(i);
        wr(`ADDR_CAUSE, 8'h00);
        @(posedge clk);
        src <= 8'hA6;
        repeat (20) @(posedge clk);
        chk({7'h00, system_reset_req}, 8'h00);
        src <= 8'h00;
        rd(`ADDR_CAUSE, 8'h01);
        rd(`ADDR_IRQ_STATUS, 8'hFF);
        wr(`ADDR_IRQ_MASK, 8'h10);
        chk({7'h00, irq}, 8'h01);
        wr(`ADDR_IRQ_STATUS, 8'hEF);
        rd(`ADDR_IRQ_STATUS, 8'h10);
        chk({7'h00, irq}, 8'h01);
        wr(`ADDR_IRQ_STATUS, 8'h10);
        chk({7'h00, irq}, 8'h00);
        close_out();
    end
endmodule // tb
`default_nettype wire
